// *** rtl/lvd_ctrl.sv ***
/*
 Low-voltage detect controller with AXI4-Lite register slave, comparator
 synchroniser, settle gating, sticky flag, interrupt and wake-up request.
 Assumes a comparator output and reference-ready level from the analog side.
*/
`timescale 1ns/1ps
`default_nettype none
module lvd_ctrl
	import lvd_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// AXI4-Lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read address
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Analog side
	input wire logic comparator_below,
	input wire logic reference_ready,
	output logic detect_power_enable,
	output logic [3:0] trip_level_select,
	output logic use_external_level_input,
	// Core side
	input wire logic core_sleeping,
	output logic wake_request,
	output logic take_vector,
	output logic irq
);
	typedef struct packed {
		logic [3:0] level;
		logic power;
		logic cmp_meta;
		logic cmp_sync;
		logic ref_meta;
		logic ref_sync;
		logic flag;
		logic mask;
		logic global_enable;
		logic wake;
		logic vector;
		logic aw_held;
		logic [3:0] aw_addr;
		logic w_held;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} lvd_state_type;

	lvd_state_type state;
	lvd_state_type next_state;
	logic settle_done;
	logic ref_stable;
	logic [31:0] read_value;
	logic read_ok;
	logic do_write;
	logic flag_set;
	logic flag_clear;

	function automatic logic addr_known(input logic [3:0] addr);
		return addr == lvd_addr_control || addr == lvd_addr_status ||
			addr == lvd_addr_mask || addr == lvd_addr_core;
	endfunction

	lvd_settle_timer u_settle
	(
		.aclk(aclk),
		.aresetn(aresetn),
		.start(state.power),
		.done(settle_done)
	);

	assign ref_stable = state.power && settle_done && state.ref_sync;

	assign flag_set = ref_stable && state.cmp_sync;
	assign do_write = state.aw_held && state.w_held && !state.bvalid;
	assign flag_clear = do_write && state.aw_addr == lvd_addr_status &&
		state.w_strb[0] && state.w_data[lvd_bit_irq_flag];

	always_comb
	begin
		read_value = 32'h0000_0000;
		read_ok = addr_known(s_axi_araddr);
		unique case (s_axi_araddr)
			lvd_addr_control:
			begin
				read_value[lvd_bit_ref_stable] = ref_stable;
				read_value[lvd_bit_power_enable] = state.power;
				read_value[lvd_bit_level_msb:0] = state.level;
			end
			lvd_addr_status:
				read_value[lvd_bit_irq_flag] = state.flag;
			lvd_addr_mask:
				read_value[lvd_bit_irq_flag] = state.mask;
			lvd_addr_core:
				read_value[lvd_bit_global_enable] = state.global_enable;
			default:
				read_value = 32'h0000_0000;
		endcase
	end

	always_comb
	begin
		next_state = state;
		next_state.cmp_meta = comparator_below;
		next_state.cmp_sync = state.cmp_meta;
		next_state.ref_meta = reference_ready;
		next_state.ref_sync = state.ref_meta;

		if (s_axi_awvalid && !state.aw_held)
		begin
			next_state.aw_held = 1'b1;
			next_state.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !state.w_held)
		begin
			next_state.w_held = 1'b1;
			next_state.w_data = s_axi_wdata;
			next_state.w_strb = s_axi_wstrb;
		end
		if (do_write)
		begin
			next_state.aw_held = 1'b0;
			next_state.w_held = 1'b0;
			next_state.bvalid = 1'b1;
			next_state.bresp = addr_known(state.aw_addr) ? lvd_resp_okay : lvd_resp_slverr;
			if (state.w_strb[0])
			begin
				unique case (state.aw_addr)
					lvd_addr_control:
					begin
						next_state.power = state.w_data[lvd_bit_power_enable];
						next_state.level = state.w_data[lvd_bit_level_msb:0];
					end
					lvd_addr_mask:
						next_state.mask = state.w_data[lvd_bit_irq_flag];
					lvd_addr_core:
						next_state.global_enable = state.w_data[lvd_bit_global_enable];
					default:
						next_state.power = state.power;
				endcase
			end
		end
		if (state.bvalid && s_axi_bready)
			next_state.bvalid = 1'b0;

		if (s_axi_arvalid && !state.rvalid)
		begin
			next_state.rvalid = 1'b1;
			next_state.rdata = read_value;
			next_state.rresp = read_ok ? lvd_resp_okay : lvd_resp_slverr;
		end
		else if (state.rvalid && s_axi_rready)
			next_state.rvalid = 1'b0;

		if (flag_set)
			next_state.flag = 1'b1;
		else if (flag_clear)
			next_state.flag = 1'b0;

		// wake-up on new flag in sleep
		if (!core_sleeping)
			next_state.wake = 1'b0;
		else if (flag_set && !state.flag)
			next_state.wake = 1'b1;

		next_state.vector = state.wake && !core_sleeping ? state.global_enable && state.mask
			: 1'b0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state <= '0;
			state.level <= lvd_level_reset;
		end
		else
			state <= next_state;
	end

	assign s_axi_awready = !state.aw_held;
	assign s_axi_wready = !state.w_held;
	assign s_axi_bvalid = state.bvalid;
	assign s_axi_bresp = state.bresp;
	assign s_axi_arready = !state.rvalid;
	assign s_axi_rvalid = state.rvalid;
	assign s_axi_rdata = state.rdata;
	assign s_axi_rresp = state.rresp;
	assign detect_power_enable = state.power;
	assign trip_level_select = state.level;
	assign use_external_level_input = state.level == lvd_level_external;
	assign wake_request = state.wake;
	assign take_vector = state.vector;
	assign irq = state.flag && state.mask;

	// Assertions
	no_early_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(state.flag) |-> $past(ref_stable))
		else $error("flag set before reference stable");
	flag_sticky_a: assert property (@(posedge aclk) disable iff (!aresetn)
		state.flag && !flag_clear |=> state.flag)
		else $error("flag dropped without clear");
	set_beats_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
		flag_set |=> state.flag)
		else $error("flag set lost");
	power_off_unstable_a: assert property (@(posedge aclk) disable iff (!aresetn)
		!state.power |-> !ref_stable)
		else $error("stable while powered off");
	irq_follows_a: assert property (@(posedge aclk) disable iff (!aresetn)
		flag_set && state.mask && !do_write |=> irq)
		else $error("irq not raised on unmasked flag");
	power_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
		do_write && state.aw_addr == lvd_addr_control && state.w_strb[0]
		|=> state.power == $past(state.w_data[lvd_bit_power_enable]))
		else $error("power enable not written");
	external_sel_a: assert property (@(posedge aclk) disable iff (!aresetn)
		do_write && state.aw_addr == lvd_addr_control && state.w_strb[0] &&
		state.w_data[lvd_bit_level_msb:0] == lvd_level_external
		|=> use_external_level_input)
		else $error("external select wrong");
	wake_on_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
		core_sleeping && flag_set && !state.flag |=> wake_request)
		else $error("no wake-up request");
	vector_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
		take_vector |-> $past(state.global_enable))
		else $error("vector without global enable");
	reset_off_a: assert property (@(posedge aclk)
		!aresetn |=> !detect_power_enable)
		else $error("detector on after reset");
	settle_wait_a: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(state.power) |-> !settle_done [*8])
		else $error("settle too short");
	stable_bit_a: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_arvalid && !state.rvalid && s_axi_araddr == lvd_addr_control
		|=> s_axi_rdata[lvd_bit_ref_stable] == $past(ref_stable))
		else $error("stable bit read wrong");
	internal_sel_a: assert property (@(posedge aclk) disable iff (!aresetn)
		do_write && state.aw_addr == lvd_addr_control && state.w_strb[0] &&
		state.w_data[lvd_bit_level_msb:0] != lvd_level_external
		|=> !use_external_level_input)
		else $error("internal tap not selected");
	level_holds_a: assert property (@(posedge aclk) disable iff (!aresetn)
		!do_write |=> $stable(state.level))
		else $error("level changed without write");
	power_holds_a: assert property (@(posedge aclk) disable iff (!aresetn)
		!do_write |=> $stable(state.power))
		else $error("power changed without write");
	read_power_a: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_arvalid && !state.rvalid && s_axi_araddr == lvd_addr_control
		|=> s_axi_rdata[lvd_bit_power_enable] == $past(state.power))
		else $error("power bit read wrong");
	read_level_a: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_arvalid && !state.rvalid && s_axi_araddr == lvd_addr_control
		|=> s_axi_rdata[lvd_bit_level_msb:0] == $past(state.level))
		else $error("level read wrong");
	read_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_arvalid && !state.rvalid && s_axi_araddr == lvd_addr_status
		|=> s_axi_rdata[lvd_bit_irq_flag] == $past(state.flag))
		else $error("flag read wrong");
	ref_sync_a: assert property (@(posedge aclk) disable iff (!aresetn)
		ref_stable |-> $past(reference_ready, 2))
		else $error("reference used unsynchronised");
	cmp_sync_a: assert property (@(posedge aclk) disable iff (!aresetn)
		flag_set |-> $past(comparator_below, 2))
		else $error("comparator used unsynchronised");
	flag_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
		flag_clear && !flag_set |=> !state.flag)
		else $error("flag not cleared");
	flag_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
		!ref_stable && !state.flag |=> !state.flag)
		else $error("flag set while unstable");
	unstable_no_irq_a: assert property (@(posedge aclk) disable iff (!aresetn)
		!ref_stable && !state.flag |=> !irq)
		else $error("irq while reference unstable");
	power_off_done_a: assert property (@(posedge aclk) disable iff (!aresetn)
		!state.power |=> !settle_done)
		else $error("settle done while powered off");
	settle_needs_power_a: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(settle_done) |-> $past(state.power))
		else $error("settle done without power");
	mask_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
		do_write && state.aw_addr == lvd_addr_mask && state.w_strb[0]
		|=> state.mask == $past(state.w_data[lvd_bit_irq_flag]))
		else $error("mask not written");
	enable_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
		do_write && state.aw_addr == lvd_addr_core && state.w_strb[0]
		|=> state.global_enable == $past(state.w_data[lvd_bit_global_enable]))
		else $error("global enable not written");
	vector_mask_a: assert property (@(posedge aclk) disable iff (!aresetn)
		take_vector |-> $past(state.mask))
		else $error("vector without mask");
	vector_pulse_a: assert property (@(posedge aclk) disable iff (!aresetn)
		take_vector |=> !take_vector)
		else $error("vector longer than one cycle");
	wake_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
		!core_sleeping |=> !wake_request)
		else $error("wake-up held while awake");
	wake_needs_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(wake_request) |-> state.flag)
		else $error("wake-up without flag");
	reset_level_a: assert property (@(posedge aclk)
		!aresetn |=> trip_level_select == lvd_level_reset)
		else $error("level not reset");
endmodule
`default_nettype wire

// *** rtl/lvd_pkg.sv ***
/*
 Package for the low-voltage detect controller: register map, field layout,
 reset values and timing constants. Assumes a 100 MHz system clock.
*/
package lvd_pkg;

	localparam int unsigned lvd_clk_mhz = 100;
	localparam int unsigned lvd_ref_settle_us = 20;
	localparam int unsigned lvd_ref_settle_cycles = lvd_ref_settle_us * lvd_clk_mhz;
	localparam int unsigned lvd_settle_width = 16;

	localparam logic [3:0] lvd_addr_control = 4'h0;
	localparam logic [3:0] lvd_addr_status = 4'h4;
	localparam logic [3:0] lvd_addr_mask = 4'h8;
	localparam logic [3:0] lvd_addr_core = 4'hC;

	localparam int unsigned lvd_bit_ref_stable = 5;
	localparam int unsigned lvd_bit_power_enable = 4;
	localparam int unsigned lvd_bit_level_msb = 3;
	localparam logic [3:0] lvd_level_external = 4'hF;
	localparam logic [3:0] lvd_level_lowest = 4'h2;
	localparam logic [3:0] lvd_level_reset = 4'h5;

	localparam int unsigned lvd_bit_irq_flag = 0;
	localparam int unsigned lvd_bit_global_enable = 0;

	localparam logic [1:0] lvd_resp_okay = 2'h0;
	localparam logic [1:0] lvd_resp_slverr = 2'h2;

	typedef enum logic [1:0] {lvd_off_type_st, lvd_settle_st, lvd_ready_st} lvd_phase_type;

endpackage

// *** rtl/lvd_settle_timer.sv ***
/*
 Reference settle timer: counts a fixed number of system clocks after the
 detector is powered. Assumes the analog reference settles within that time.
*/
`timescale 1ns/1ps
`default_nettype none
module lvd_settle_timer
	import lvd_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Control
	input wire logic start,
	// Status
	output logic done
);
	typedef struct packed {
		logic [lvd_settle_width-1:0] count;
		logic done;
	} lvd_timer_type;

	lvd_timer_type state;
	lvd_timer_type next_state;

	always_comb
	begin
		next_state = state;
		if (!start)
		begin
			next_state.count = '0;
			next_state.done = 1'b0;
		end
		else if (!state.done)
		begin
			if (state.count == lvd_settle_width'(lvd_ref_settle_cycles - 1))
				next_state.done = 1'b1;
			else
				next_state.count = state.count + 1'b1;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			state <= '0;
		else
			state <= next_state;
	end

	assign done = state.done;
endmodule
`default_nettype wire

// *** verification/lvd_analog_model.sv ***
/*
 Analog side model: supply comparator and reference of the detector.
 Assumes power, level code and pin select from the controller.
*/
`timescale 1ns/1ps
`default_nettype none
module lvd_analog_model
(
	// Clock
	input wire logic aclk,
	// Controller side
	input wire logic detect_power_enable,
	input wire logic [3:0] trip_level_select,
	input wire logic use_external_level_input,
	// Supply and pin
	input wire logic [3:0] supply_level,
	input wire logic external_level_low,
	// Detector outputs
	output logic comparator_below,
	output logic reference_ready
);
	logic [2:0] warm;
	always_ff @(posedge aclk)
	begin
		warm <= detect_power_enable ? {warm[1:0], 1'b1} : 3'h0;
	end
	assign reference_ready = warm[2];
	assign comparator_below = detect_power_enable && (use_external_level_input ?
		external_level_low : supply_level < trip_level_select);
endmodule
`default_nettype wire

// *** verification/lvd_ctrl_bench.sv ***
/*
 Bench for the detect controller: bus tasks and register tests.
 Assumes the analog model at the far side and the package constants.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin mismatches++; \
	$display("wrong value at %0t: got %h expected %h", $time, (a), (b)); end end
module lvd_ctrl_bench;
	import lvd_pkg::*;
	logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [3:0] awaddr = 0, araddr = 0, supply = 4'hF;
	logic [31:0] wdata = 0;
	logic ext_low = 0, sleep = 0, awready, wready, bvalid, arready, rvalid, below, ready;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic power, use_ext, wake, take_vector, irq;
	logic [3:0] level;
	int mismatches = 0, n_checks = 0, n_vec = 0;
	localparam logic [1:0] ok = lvd_resp_okay;
	lvd_ctrl i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .comparator_below(below), .reference_ready(ready),
		.detect_power_enable(power), .trip_level_select(level),
		.use_external_level_input(use_ext), .core_sleeping(sleep),
		.wake_request(wake), .take_vector(take_vector), .irq(irq));
	lvd_analog_model i_analog (.aclk(aclk), .detect_power_enable(power),
		.trip_level_select(level), .use_external_level_input(use_ext),
		.supply_level(supply), .external_level_low(ext_low),
		.comparator_below(below), .reference_ready(ready));
	always #5 aclk = ~aclk;
	always @(posedge aclk)
	begin
		if (take_vector === 1'b1)
			n_vec++;
	end
	task automatic summarize;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [1:0] er);
		@(posedge aclk);
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end
		while (bvalid !== 1'b1);
		bready <= 1'b0;
		`CHK(bresp, er)
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] e, input logic [1:0] er);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (arready)
				arvalid <= 1'b0;
		end
		while (rvalid !== 1'b1);
		rready <= 1'b0;
		`CHK(rdata, {24'h0, e})
		`CHK(rresp, er)
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge aclk);
	endtask
	initial
	begin
		#100000;
		mismatches++;
		summarize();
	end
	initial
	begin
		cyc(2);
		aresetn <= 1'b1;
		rd(lvd_addr_control, 8'h05, ok);
		rd(lvd_addr_status, 8'h00, ok);
		rd(4'h2, 8'h00, lvd_resp_slverr);
		wr(4'h2, 8'h01, lvd_resp_slverr);
		for (int c = 2; c < 15; c++)
		begin
			wr(lvd_addr_control, 8'(c), ok);
			`CHK(level, 4'(c))
			`CHK(use_ext, 1'b0)
		end
		supply <= 4'h3;
		wr(lvd_addr_control, 8'h1E, ok);
		`CHK(power, 1'b1)
		cyc(lvd_ref_settle_cycles - 30);
		rd(lvd_addr_control, 8'h1E, ok);
		rd(lvd_addr_status, 8'h00, ok);
		cyc(40);
		rd(lvd_addr_control, 8'h3E, ok);
		rd(lvd_addr_status, 8'h01, ok);
		supply <= 4'hF;
		wr(lvd_addr_status, 8'h01, ok);
		rd(lvd_addr_status, 8'h00, ok);
		wr(lvd_addr_control, 8'h1F, ok);
		`CHK(use_ext, 1'b1)
		ext_low <= 1'b1;
		cyc(6);
		rd(lvd_addr_status, 8'h01, ok);
		ext_low <= 1'b0;
		wr(lvd_addr_status, 8'h01, ok);
		wr(lvd_addr_mask, 8'h01, ok);
		`CHK(irq, 1'b0)
		ext_low <= 1'b1;
		cyc(6);
		`CHK(irq, 1'b1)
		ext_low <= 1'b0;
		rd(lvd_addr_status, 8'h01, ok);
		wr(lvd_addr_mask, 8'h00, ok);
		`CHK(irq, 1'b0)
		for (int g = 1; g >= 0; g--)
		begin
			wr(lvd_addr_status, 8'h01, ok);
			wr(lvd_addr_mask, 8'h01, ok);
			wr(lvd_addr_core, 8'(g), ok);
			sleep <= 1'b1;
			ext_low <= 1'b1;
			cyc(6);
			`CHK(wake, 1'b1)
			sleep <= 1'b0;
			ext_low <= 1'b0;
			cyc(6);
			`CHK(n_vec, 1)
		end
		rd(lvd_addr_mask, 8'h01, ok);
		rd(lvd_addr_core, 8'h00, ok);
		wr(lvd_addr_control, 8'h0F, ok);
		rd(lvd_addr_control, 8'h0F, ok);
		wr(lvd_addr_control, 8'h1A, ok);
		aresetn <= 1'b0;
		cyc(2);
		aresetn <= 1'b1;
		rd(lvd_addr_control, 8'h05, ok);
		`CHK(power, 1'b0)
		summarize();
	end
endmodule
`default_nettype wire
